//--- shared/tcc_defs.vh
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// Channel direction select codes
`define TCC_DIR_OUTPUT      2'b00
`define TCC_DIR_OWN_INPUT   2'b01
`define TCC_DIR_NEIGHBOUR   2'b10
`define TCC_DIR_TRIGGER     2'b11

// Capture prescale settings
`define TCC_PSC_BYPASS      2'b00
`define TCC_PSC_DIV2        2'b01
`define TCC_PSC_DIV4        2'b10
`define TCC_PSC_DIV8        2'b11

// Reset values
`define TCC_RST_VALUE       16'h0000
`define TCC_RST_BYTE        8'h00

// Filter counter width and the documented eight-sample setting
`define TCC_FILT_CODE_8     4'h3
`define TCC_FILT_CNT_W      5

`endif

//--- core/tcc_input_filter.v
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"

module tcc_input_filter (
   input  wire       clk_sys,
   input  wire       rst,
   input  wire       timer_input,
   input  wire [3:0] input_filter_setting,
   output reg        filtered_input
);

   // ----------------------------------------------------------------
   // Resynchroniser
   // ----------------------------------------------------------------
   reg sync_a;
   reg sync_b;

   always @(posedge clk_sys) begin
      if (rst) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else begin
         sync_a <= timer_input;
         sync_b <= sync_a;
      end
   end

   // ----------------------------------------------------------------
   // Sample count per setting
   // ----------------------------------------------------------------
   function [4:0] tcc_filt_len;
      input [3:0] code;
      begin
         case (code)
            4'h0:    tcc_filt_len = 5'd1;
            4'h1:    tcc_filt_len = 5'd2;
            4'h2:    tcc_filt_len = 5'd4;
            4'h3:    tcc_filt_len = 5'd8;
            4'h4:    tcc_filt_len = 5'd12;
            4'h5:    tcc_filt_len = 5'd16;
            default: tcc_filt_len = 5'd24;
         endcase
      end
   endfunction

   reg  [`TCC_FILT_CNT_W-1:0] same_count;
   wire [4:0]                 need = tcc_filt_len(input_filter_setting);

   // A level differing from the output must stay for need samples
   always @(posedge clk_sys) begin
      if (rst) begin
         same_count     <= 5'd0;
         filtered_input <= 1'b0;
      end else if (sync_b == filtered_input) begin
         same_count <= 5'd0;
      end else if (same_count + 5'd1 >= need) begin
         filtered_input <= sync_b;
         same_count     <= 5'd0;
      end else begin
         same_count <= same_count + 5'd1;
      end
   end

endmodule // tcc_input_filter
`default_nettype wire

//--- core/tcc_prescaler.v
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"

module tcc_prescaler (
   input  wire       clk_sys,
   input  wire       rst,
   input  wire       enable,
   input  wire       edge_in,
   input  wire [1:0] capture_prescale_setting,
   output wire       prescaled_capture_signal
);

   reg [2:0] edge_count;
   reg [2:0] limit;

   always @* begin
      case (capture_prescale_setting)
         `TCC_PSC_DIV2: limit = 3'd1;
         `TCC_PSC_DIV4: limit = 3'd3;
         `TCC_PSC_DIV8: limit = 3'd7;
         default:       limit = 3'd0;
      endcase
   end

   // Bypass yields every valid edge
   assign prescaled_capture_signal = edge_in && (edge_count == limit);

   // Counter restarts while disabled so the ratio starts clean
   always @(posedge clk_sys) begin
      if (rst || !enable) begin
         edge_count <= 3'd0;
      end else if (edge_in) begin
         edge_count <= (edge_count == limit) ? 3'd0 : edge_count + 3'd1;
      end
   end

endmodule // tcc_prescaler
`default_nettype wire

//--- core/tcc_channel.v
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"

module tcc_channel (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        timer_input,
   input  wire        neighbour_edge,
   input  wire        trigger_edge,
   input  wire [15:0] counter_value,
   input  wire        update_event,
   input  wire [1:0]  channel_direction_select,
   input  wire        channel_edge_polarity,
   input  wire        channel_capture_enable,
   input  wire [3:0]  input_filter_setting,
   input  wire [1:0]  capture_prescale_setting,
   input  wire        compare_preload_enable,
   input  wire        capture_interrupt_enable,
   input  wire        capture_generate_bit,
   input  wire        write_high,
   input  wire        write_low,
   input  wire [7:0]  write_data,
   input  wire        read_high,
   input  wire        read_low,
   input  wire        clear_capture_flag,
   input  wire        clear_overcapture_flag,
   output reg  [7:0]  read_data,
   output wire        edge_selected_input,
   output wire        rising_selected,
   output wire        falling_selected,
   output reg         capture_flag,
   output reg         overcapture_flag,
   output wire        capture_irq,
   output reg         compare_match,
   output wire        input_mode,
   output reg  [15:0] capture_value_register
);

   // ----------------------------------------------------------------
   // Input stage
   // ----------------------------------------------------------------
   wire filtered_input;
   reg  filtered_d;

   tcc_input_filter u_filter (
      .clk_sys              (clk_sys),
      .rst                  (rst),
      .timer_input          (timer_input),
      .input_filter_setting (input_filter_setting),
      .filtered_input       (filtered_input)
   );

   always @(posedge clk_sys) begin
      if (rst) begin
         filtered_d <= 1'b0;
      end else begin
         filtered_d <= filtered_input;
      end
   end

   assign rising_selected  = filtered_input && !filtered_d;
   assign falling_selected = !filtered_input && filtered_d;

   // Same edge goes to the trigger controller and to capture
   assign edge_selected_input = channel_edge_polarity ? falling_selected
                                                      : rising_selected;

   // Neighbour path lets two channels share one pin for PWM input
   reg raw_capture_edge;

   always @* begin
      case (channel_direction_select)
         `TCC_DIR_OWN_INPUT: raw_capture_edge = edge_selected_input;
         `TCC_DIR_NEIGHBOUR: raw_capture_edge = neighbour_edge;
         `TCC_DIR_TRIGGER:   raw_capture_edge = trigger_edge;
         default:            raw_capture_edge = 1'b0;
      endcase
   end

   assign input_mode = (channel_direction_select != `TCC_DIR_OUTPUT);

   wire prescaled_capture_signal;

   tcc_prescaler u_prescaler (
      .clk_sys                  (clk_sys),
      .rst                      (rst),
      .enable                   (input_mode && channel_capture_enable),
      .edge_in                  (raw_capture_edge),
      .capture_prescale_setting (capture_prescale_setting),
      .prescaled_capture_signal (prescaled_capture_signal)
   );

   // ----------------------------------------------------------------
   // Capture event
   // ----------------------------------------------------------------
   // Generate bit captures in input mode even with no edge, as software expects; in output mode it only sets the flag
   wire hw_capture = input_mode && channel_capture_enable
                     && prescaled_capture_signal;
   wire sw_capture = capture_generate_bit;
   wire capture    = hw_capture || (sw_capture && input_mode);
   wire event_hit  = capture || (sw_capture && !input_mode);

   // ----------------------------------------------------------------
   // Preload / shadow pair
   // ----------------------------------------------------------------
   reg  [15:0] shadow;
   reg  [7:0]  high_pending;
   reg         write_in_progress;
   reg         read_in_progress;
   reg         capture_pending;

   // Writes ignored in input mode: register is read-only there
   wire sw_write_high = write_high && !input_mode;
   wire sw_write_low  = write_low  && !input_mode;

   always @(posedge clk_sys) begin
      if (rst) begin
         shadow                 <= `TCC_RST_VALUE;
         capture_value_register <= `TCC_RST_VALUE;
         high_pending           <= `TCC_RST_BYTE;
         write_in_progress      <= 1'b0;
         read_in_progress       <= 1'b0;
         capture_pending        <= 1'b0;
      end else if (input_mode) begin
         write_in_progress <= 1'b0;
         if (capture) begin
            shadow <= counter_value;
         end
         if (read_high) begin
            read_in_progress <= 1'b1;
         end else if (read_low) begin
            read_in_progress <= 1'b0;
         end
         // Preload follows shadow unless frozen; a late capture is kept
         if (read_in_progress || read_high) begin
            if (capture) begin
               capture_pending <= 1'b1;
            end
         end else if (capture) begin
            // A fresh capture supersedes one held over from the freeze
            capture_value_register <= counter_value;
            capture_pending        <= 1'b0;
         end else if (capture_pending) begin
            capture_value_register <= shadow;
            capture_pending        <= 1'b0;
         end
      end else begin
         read_in_progress <= 1'b0;
         capture_pending  <= 1'b0;
         // Software always lands in preload, never shadow
         if (sw_write_high) begin
            capture_value_register[15:8] <= write_data;
            high_pending                 <= write_data;
            write_in_progress            <= 1'b1;
         end else if (sw_write_low) begin
            capture_value_register[7:0] <= write_data;
            write_in_progress           <= 1'b0;
         end
         // Transfer blocked between the two byte writes
         if (!write_in_progress && !sw_write_high) begin
            if (!compare_preload_enable || update_event) begin
               shadow <= capture_value_register;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Outside a sequence the preload tracks captures, so a lone low
   // read returns whatever is there at the time of the read
   always @(posedge clk_sys) begin
      if (rst) begin
         read_data <= `TCC_RST_BYTE;
      end else if (read_high) begin
         read_data <= capture_value_register[15:8];
      end else if (read_low) begin
         read_data <= capture_value_register[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Compare against shadow
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (rst) begin
         compare_match <= 1'b0;
      end else begin
         compare_match <= !input_mode && (counter_value == shadow);
      end
   end

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   wire low_read_clear = read_low && input_mode;

   // Set wins over a clear in the same cycle
   always @(posedge clk_sys) begin
      if (rst) begin
         capture_flag     <= 1'b0;
         overcapture_flag <= 1'b0;
      end else begin
         if (event_hit) begin
            capture_flag <= 1'b1;
         end else if (clear_capture_flag || low_read_clear) begin
            capture_flag <= 1'b0;
         end
         if (capture && capture_flag) begin
            overcapture_flag <= 1'b1;
         end else if (clear_overcapture_flag) begin
            overcapture_flag <= 1'b0;
         end
      end
   end

   assign capture_irq = capture_flag && capture_interrupt_enable;

endmodule // tcc_channel
`default_nettype wire

//--- verif/tcc_channel_props.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_channel_props (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        timer_input,
   input wire logic [1:0]  channel_direction_select,
   input wire logic        channel_edge_polarity,
   input wire logic        channel_capture_enable,
   input wire logic [3:0]  input_filter_setting,
   input wire logic        capture_interrupt_enable,
   input wire logic        capture_generate_bit,
   input wire logic        read_high,
   input wire logic        read_low,
   input wire logic        clear_capture_flag,
   input wire logic        clear_overcapture_flag,
   input wire logic        edge_selected_input,
   input wire logic        rising_selected,
   input wire logic        falling_selected,
   input wire logic        capture_flag,
   input wire logic        overcapture_flag,
   input wire logic        capture_irq,
   input wire logic        input_mode,
   input wire logic [15:0] capture_value_register
);
   logic       reading;
   logic       prev_pin;
   logic [4:0] stable_cnt;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Raw pin age; the synchroniser adds delay, so a pin change just before an edge is accepted can break this bound
   always @(posedge clk_sys) begin
      prev_pin <= timer_input;
      if (rst || timer_input != prev_pin) stable_cnt <= 5'd0;
      else if (stable_cnt != 5'd31) stable_cnt <= stable_cnt + 5'd1;
      if (rst) reading <= 1'b0;
      else if (read_high) reading <= 1'b1;
      else if (read_low) reading <= 1'b0;
   end
   irq_gating_a: assert property (
      capture_irq == (capture_flag && capture_interrupt_enable))
      else $error("irq differs from flag and enable");
   dir_mode_a: assert property (
      input_mode == (channel_direction_select != 2'b00))
      else $error("input mode does not follow direction");
   ovf_clear_a: assert property (
      $fell(overcapture_flag) |-> $past(clear_overcapture_flag))
      else $error("over-capture cleared without write");
   flag_clear_a: assert property (
      $fell(capture_flag) |-> $past(clear_capture_flag || read_low))
      else $error("capture flag cleared without cause");
   ovf_cause_a: assert property (
      $rose(overcapture_flag) |-> $past(capture_flag))
      else $error("over-capture without pending flag");
   read_freeze_a: assert property (
      reading && !read_low && input_mode |=> $stable(capture_value_register))
      else $error("capture value moved during read");
   flag_cause_a: assert property (
      $rose(capture_flag) |-> $past(channel_capture_enable || capture_generate_bit))
      else $error("capture flag set while disabled");
   filter_len_a: assert property (
      edge_selected_input && input_filter_setting == 4'h3 |-> stable_cnt >= 5'd8)
      else $error("edge accepted before eight samples");
   edge_pick_a: assert property (
      edge_selected_input == (channel_edge_polarity ? falling_selected : rising_selected))
      else $error("edge select ignores polarity");
   // Pin level is taken to name the edge, though the pin can change again within the synchroniser delay before the edge is accepted
   edge_level_a: assert property (
      edge_selected_input && input_filter_setting == 4'h3
      |-> timer_input == !channel_edge_polarity)
      else $error("edge level disagrees with pin");
   cover property ($rose(overcapture_flag));
   cover property (reading ##1 read_low);
   cover property (capture_generate_bit ##1 capture_flag);
endmodule // tcc_channel_props
bind tcc_channel tcc_channel_props tcc_channel_props_i (.clk_sys, .rst, .timer_input,
   .channel_direction_select, .channel_edge_polarity, .channel_capture_enable,
   .input_filter_setting, .capture_interrupt_enable, .capture_generate_bit, .read_high,
   .read_low, .clear_capture_flag, .clear_overcapture_flag, .edge_selected_input,
   .rising_selected, .falling_selected, .capture_flag, .overcapture_flag, .capture_irq,
   .input_mode, .capture_value_register);
`default_nettype wire

//--- verif/tcc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
   input  wire logic        clk_sys,
   output var  logic        timer_input,
   output var  logic [15:0] counter_value
);
   initial begin
      timer_input = 1'b0;
      counter_value = 16'h0000;
   end
   // Count is held still so that a capture has one exact expected value
   task automatic drive(input logic lvl, input int n);
      @(posedge clk_sys) timer_input <= lvl;
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic count(input logic [15:0] v);
      @(posedge clk_sys) counter_value <= v;
   endtask
endmodule // tcc_pin_model
`default_nettype wire

//--- verif/tcc_channel_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_channel_tb_top;
   logic        clk_sys, rst, pol, en, ie, ope;
   logic [1:0]  dir, psc;
   logic [3:0]  filt;
   logic [9:0]  stb;
   logic [7:0]  wdata, rdata;
   logic        flag, ovf, irq, pin, cmp, imode;
   logic [15:0] cnt, val;
   int          num_errors, checked;
   tcc_pin_model pin_i (.clk_sys(clk_sys), .timer_input(pin), .counter_value(cnt));
   tcc_channel tcc_channel_i (.clk_sys(clk_sys), .rst(rst), .timer_input(pin),
      .neighbour_edge(stb[7]), .trigger_edge(stb[8]), .counter_value(cnt), .update_event(stb[9]),
      .channel_direction_select(dir), .channel_edge_polarity(pol), .channel_capture_enable(en),
      .input_filter_setting(filt), .capture_prescale_setting(psc),
      .compare_preload_enable(ope), .capture_interrupt_enable(ie),
      .capture_generate_bit(stb[6]), .write_high(stb[2]), .write_low(stb[3]),
      .write_data(wdata), .read_high(stb[0]), .read_low(stb[1]),
      .clear_capture_flag(stb[4]), .clear_overcapture_flag(stb[5]), .read_data(rdata),
      .edge_selected_input(), .rising_selected(), .falling_selected(), .capture_flag(flag),
      .overcapture_flag(ovf), .capture_irq(irq), .compare_match(cmp), .input_mode(imode),
      .capture_value_register(val));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // Strobe 0 read high, 1 read low, 2 write high, 3 write low, 4/5 clears, 6 generate,
   // 7 neighbour edge, 8 trigger edge, 9 update event
   task automatic strobe(input int k, input logic [7:0] d);
      @(posedge clk_sys) begin
         stb[k] <= 1'b1;
         wdata <= d;
      end
      @(posedge clk_sys) stb[k] <= 1'b0;
      @(posedge clk_sys) #1;
   endtask
   task automatic rd(input int k, input logic [7:0] e);
      strobe(k, 8'h00);
      chk("read_data", {8'h00, e}, {8'h00, rdata});
   endtask
   task automatic conclude;
      if (num_errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_sys);
      num_errors++;
      conclude();
   end
   initial begin
      {rst, stb, wdata, pol, ie, ope, psc} = '0;
      rst = 1'b1;
      {dir, filt, en} = {2'b01, 4'h3, 1'b1};
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      pin_i.count(16'h1234);
      #1 chk("reset value", 16'h0000, val);
      chk("reset flag", 16'h0000, {15'h0000, flag});
      ie <= 1'b1;
      pin_i.drive(1'b1, 5);
      pin_i.drive(1'b0, 20);
      chk("glitch flag", 16'h0000, {15'h0000, flag});
      pin_i.drive(1'b1, 30);
      chk("capture", 16'h1234, val);
      chk("flag", 16'h0001, {15'h0000, flag});
      chk("irq", 16'h0001, {15'h0000, irq});
      pin_i.count(16'h5678);
      pin_i.drive(1'b0, 20);
      pin_i.drive(1'b1, 30);
      chk("second capture", 16'h5678, val);
      chk("overcapture", 16'h0001, {15'h0000, ovf});
      rd(0, 8'h56);
      pin_i.count(16'h9abc);
      pin_i.drive(1'b0, 20);
      pin_i.drive(1'b1, 30);
      chk("frozen value", 16'h5678, val);
      rd(1, 8'h78);
      chk("released value", 16'h9abc, val);
      rd(1, 8'hbc);
      chk("flag after low read", 16'h0000, {15'h0000, flag});
      chk("overcapture kept", 16'h0001, {15'h0000, ovf});
      strobe(5, 8'h00);
      chk("overcapture cleared", 16'h0000, {15'h0000, ovf});
      pin_i.count(16'h0f0f);
      pol <= 1'b1;
      pin_i.drive(1'b0, 30);
      chk("falling capture", 16'h0f0f, val);
      strobe(4, 8'h00);
      chk("flag written 0", 16'h0000, {15'h0000, flag});
      en <= 1'b0;
      pin_i.count(16'h7777);
      pin_i.drive(1'b1, 30);
      pin_i.drive(1'b0, 30);
      chk("disabled value", 16'h0f0f, val);
      chk("disabled flag", 16'h0000, {15'h0000, flag});
      pin_i.count(16'h4242);
      strobe(6, 8'h00);
      chk("generated capture", 16'h4242, val);
      chk("generated irq", 16'h0001, {15'h0000, irq});
      ie <= 1'b0;
      @(posedge clk_sys) #1 chk("masked irq", 16'h0000, {15'h0000, irq});
      strobe(2, 8'h11);
      strobe(3, 8'h22);
      chk("read-only value", 16'h4242, val);
      dir <= 2'b00;
      strobe(2, 8'hab);
      strobe(3, 8'hcd);
      rd(0, 8'hab);
      rd(1, 8'hcd);
      chk("preload", 16'habcd, val);
      chk("output mode", 16'h0000, {15'h0000, imode});
      pin_i.count(16'habcd);
      @(posedge clk_sys) #1 chk("compare match", 16'h0001, {15'h0000, cmp});
      strobe(2, 8'h56);
      chk("blocked shadow", 16'h0001, {15'h0000, cmp});
      strobe(3, 8'h78);
      @(posedge clk_sys) #1 chk("shadow loaded", 16'h0000, {15'h0000, cmp});
      ope <= 1'b1;
      strobe(2, 8'h12);
      strobe(3, 8'h34);
      chk("preload written", 16'h1234, val);
      pin_i.count(16'h5678);
      @(posedge clk_sys) #1 chk("preload only", 16'h0001, {15'h0000, cmp});
      strobe(9, 8'h00);
      chk("update transfer", 16'h0000, {15'h0000, cmp});
      {dir, en} <= {2'b10, 1'b1};
      pin_i.count(16'h1111);
      chk("input mode", 16'h0001, {15'h0000, imode});
      strobe(7, 8'h00);
      chk("neighbour capture", 16'h1111, val);
      dir <= 2'b11;
      pin_i.count(16'h2222);
      strobe(8, 8'h00);
      chk("trigger capture", 16'h2222, val);
      psc <= 2'b01;
      pin_i.count(16'h3333);
      strobe(8, 8'h00);
      chk("first of two", 16'h2222, val);
      strobe(8, 8'h00);
      chk("second of two", 16'h3333, val);
      conclude();
   end
endmodule // tcc_channel_tb_top
`default_nettype wire
